// ==== hdl/epp_cycle_engine_regs.vh ====
// constants for the enhanced parallel port cycle engine
// assumes 40 MHz aclk and a 32-bit register bus with word-aligned registers
`ifndef EPP_CYCLE_ENGINE_REGS_VH
`define EPP_CYCLE_ENGINE_REGS_VH

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define IDX_DATA 6'h00
`define IDX_STAT 6'h01
`define IDX_CTL 6'h02
`define IDX_EADDR 6'h03
`define IDX_EDATA0 6'h04
`define IDX_EDATA3 6'h07
`define IDX_MODE 6'h08

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTL_STROBE 0
`define CTL_AUTOFD 1
`define CTL_INIT 2
`define CTL_SELIN 3
`define CTL_IRQE 4
`define CTL_PCD 5
`define STAT_TIMEOUT_FLAG 0
`define MODE_EPP 0
`define MODE_V17 1

// ----------------------------------------
// reset values and answers
// ----------------------------------------
`define CTL_RST 6'h00
`define MODE_RST 2'h0
`define BYTE_RST 8'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 40
`define WD_US 10
`define WD_CYC 10'h190 // watchdog span in aclk cycles, sized to its counter
`define HOST_HOLD_CYC 3'h3

`endif

// ==== hdl/epp_cycle_engine.v ====
// epp cycle engine: register slave on axi4-lite plus the epp address/data cycle sequencer
// assumes wait_n may be asynchronous; other port inputs are synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
`include "epp_cycle_engine_regs.vh"

// What this block does
// [RULE1] interlocked variant: hold iochrdy low from command start until transfer may finish
// [RULE2] interlocked: if wait_n high at start, wait for it low before moving outputs
// [RULE3] interlocked write: byte on bus, direction low, write_n low, then strobe
// [RULE4] interlocked write: on wait_n high drop strobe, latch byte, release iochrdy
// [RULE5] peripheral raises wait_n after setup, captures byte, then lowers wait_n
// [RULE6] interlocked read: release bus, write_n high, then strobe with direction high
// [RULE7] interlocked read: on wait_n high capture bus, drop strobe, answer, release iochrdy
// [RULE8] peripheral drives data before raising wait_n, then releases bus, lowers wait_n
// [RULE9] outside cycles, pins follow control register and direction follows its bit
// [RULE10] strobe-follows-host variant: abort cycles over 10 us, flag in status bit 0
// [RULE11] software clears control bits 0, 1, 3 and sets direction before such cycles
// [RULE12] strobe-follows-host: iochrdy low while wait_n low, until wait_n high or timeout
// [RULE13] strobe-follows-host write: byte on bus at command, then matching strobe
// [RULE14] strobe-follows-host write: strobe drops and byte latches when host command ends
// [RULE15] strobe-follows-host read: direction bit sets write_n; strobe spans host command
// [RULE16] peripheral raises wait_n to acknowledge, lowers it when ready again
// [RULE17] direction output low for write, high while direction bit set or read cycle
// [RULE18] only write_n may be overridden by the control register during a cycle
// [RULE19] interrupt input passes through uninverted, active high
// [RULE20] address strobe only for address cycles, data strobe only for data cycles
// [RULE21] active-low peripheral reset output
// [RULE22] interlocked: abort and flag timeout if wait_n not raised within 10 us
// [RULE23] timeout flag cleared by reset or writing one; zero writes do nothing
// [RULE24] address port runs address cycles, four data ports run data cycles, epp mode only
// [RULE25] interlocked write with direction bit set runs a read-like cycle, no error
// [RULE26] wait_n synchronised; variant chosen from a mode setting
module epp_cycle_engine (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7:0] port_data_bus_in,
  output wire [7:0] port_data_bus_out,
  output wire port_data_bus_oe,
  input wire wait_n,
  input wire intr,
  input wire err_n,
  input wire select,
  input wire paper_end,
  input wire ack_n,
  input wire busy,
  output wire write_n,
  output wire data_strobe_n,
  output wire addr_strobe_n,
  output wire periph_reset_n,
  output wire port_dir_out,
  output wire iochrdy,
  output wire irq,
  output wire timeout_flag
);

  // ----------------------------------------
  // states and limits
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WLOW = 3'h1;
  localparam [2:0] ST_SETUP = 3'h2;
  localparam [2:0] ST_STRB = 3'h3;
  localparam [2:0] ST_HOLD = 3'h4;
  localparam [2:0] ST_RESP = 3'h5;
  localparam [9:0] WD_LIM = `WD_CYC; // 10 us at 40 MHz
  // state walk:
  // idle answers register accesses next cycle and starts epp cycles on the port offsets
  // wlow is interlocked only and waits for the peripheral to show ready
  // setup lets byte and write line settle one cycle ahead of the strobe
  // strb keeps the strobe low until the synchronised wait_n rises
  // hold stands in for the host command tail of the strobe-follows-host variant
  // resp keeps the answer up until the bus master takes it

  reg [2:0] st_r;
  reg [5:0] ctl_r;
  reg [1:0] mode_r;
  reg [7:0] port_data_bus_r;
  reg [7:0] wbyte_r;
  reg tmo_r;
  reg cyc_rd_r;
  reg cyc_addr_r;
  reg is_wr_r;
  reg [9:0] wd_r;
  reg [2:0] hold_r;
  reg nw_meta_r;
  reg nw_s_r;
  reg tmo_set;
  reg tmo_clr;
  reg [7:0] reg_rd;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // epp ports sit at indices 3..7
  function is_epp;
    input [5:0] idx;
    begin
      is_epp = (idx >= `IDX_EADDR) && (idx <= `IDX_EDATA3);
    end
  endfunction

  function is_mapped;
    input [5:0] idx;
    begin
      is_mapped = (idx <= `IDX_MODE);
    end
  endfunction

  // address port gets the address strobe, the data ports the data strobe
  function is_addr_port;
    input [5:0] idx;
    begin
      is_addr_port = (idx == `IDX_EADDR);
    end
  endfunction

  // epp ports answer only while epp mode is on; unmapped indices always refuse
  function [1:0] resp_for;
    input [5:0] idx;
    input en;
    begin
      resp_for = (is_mapped(idx) && (en || !is_epp(idx))) ? `RESP_OKAY : `RESP_SLVERR;
    end
  endfunction

  wire [5:0] widx = s_axi_awaddr[7:2];
  wire [5:0] ridx = s_axi_araddr[7:2];
  wire epp_en = mode_r[`MODE_EPP];
  wire v17 = mode_r[`MODE_V17];
  wire wr_go = (st_r == ST_IDLE) && s_axi_awvalid && s_axi_wvalid;
  wire rd_go = (st_r == ST_IDLE) && s_axi_arvalid && !wr_go;
  wire in_cyc = (st_r == ST_WLOW) || (st_r == ST_SETUP) || (st_r == ST_STRB) || (st_r == ST_HOLD);
  wire eng_act = (st_r == ST_SETUP) || (st_r == ST_STRB) || (st_r == ST_HOLD);
  wire strb_on = (st_r == ST_STRB) || (st_r == ST_HOLD);
  wire wd_hit = in_cyc && (wd_r == WD_LIM - 10'h001);
  // cycle end events: host tail done, peripheral acknowledge, or watchdog
  wire hold_done = (st_r == ST_HOLD) && (hold_r == `HOST_HOLD_CYC - 3'h1);
  wire ack_done = (st_r == ST_STRB) && nw_s_r && !v17;
  wire cyc_end = in_cyc && (wd_hit || hold_done || ack_done);
  // interlocked stall covers wait-for-ready, setup and strobe
  wire stall_lock = (st_r == ST_WLOW) || (eng_act && (st_r != ST_HOLD));
  // strobe-follows-host stall only while the peripheral holds wait_n low
  wire stall_follow = strb_on && !nw_s_r;

  // ----------------------------------------
  // bus handshakes, write wins when both arrive together
  // ----------------------------------------
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  // ----------------------------------------
  // register read mux and timeout flag events
  // ----------------------------------------
  always @* begin
    reg_rd = `BYTE_RST;
    if (ridx == `IDX_DATA) begin
      reg_rd = port_data_bus_in;
    end else if (ridx == `IDX_STAT) begin
      reg_rd = {~busy, ack_n, paper_end, select, err_n, 2'h0, tmo_r};
    end else if (ridx == `IDX_CTL) begin
      reg_rd = {2'h0, ctl_r};
    end else if (ridx == `IDX_MODE) begin
      reg_rd = {6'h00, mode_r};
    end
    tmo_set = wd_hit; // [RULE10] [RULE22]
    tmo_clr = wr_go && (widx == `IDX_STAT) && s_axi_wstrb[0] && s_axi_wdata[`STAT_TIMEOUT_FLAG]; // [RULE23]
  end

  // ----------------------------------------
  // cycle sequencer and register file
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      ctl_r <= `CTL_RST;
      mode_r <= `MODE_RST;
      port_data_bus_r <= `BYTE_RST;
      wbyte_r <= `BYTE_RST;
      tmo_r <= 1'b0;
      cyc_rd_r <= 1'b0;
      cyc_addr_r <= 1'b0;
      is_wr_r <= 1'b0;
      wd_r <= 10'h000;
      hold_r <= 3'h0;
      nw_meta_r <= 1'b1;
      nw_s_r <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      // two-stage synchroniser; only nw_s_r feeds logic
      nw_meta_r <= wait_n; // [RULE26]
      nw_s_r <= nw_meta_r;
      // set beats clear so a timeout in the clearing cycle survives
      tmo_r <= tmo_set | (tmo_r & ~tmo_clr); // [RULE23]
      // watchdog runs from command start to cycle end
      if (in_cyc) begin
        wd_r <= wd_r + 10'h001;
      end else begin
        wd_r <= 10'h000;
      end
      case (st_r)
        ST_IDLE: begin
          if (wr_go) begin
            is_wr_r <= 1'b1;
            wbyte_r <= s_axi_wdata[7:0];
            cyc_addr_r <= is_addr_port(widx); // [RULE24]
            cyc_rd_r <= ctl_r[`CTL_PCD]; // [RULE25]
            s_axi_bresp <= resp_for(widx, epp_en);
            if (epp_en && is_epp(widx) && s_axi_wstrb[0]) begin
              // strobe-follows-host drives the byte from the command start
              if (v17 && !ctl_r[`CTL_PCD]) begin
                port_data_bus_r <= s_axi_wdata[7:0]; // [RULE13]
              end
              st_r <= v17 ? ST_SETUP : ST_WLOW; // [RULE1] [RULE13]
            end else begin
              if (s_axi_wstrb[0]) begin
                if (widx == `IDX_DATA) begin
                  port_data_bus_r <= s_axi_wdata[7:0];
                end else if (widx == `IDX_CTL) begin
                  ctl_r <= s_axi_wdata[5:0];
                end else if (widx == `IDX_MODE) begin
                  mode_r <= s_axi_wdata[1:0]; // [RULE26]
                end
              end
              s_axi_bvalid <= 1'b1;
              st_r <= ST_RESP;
            end
          end else if (rd_go) begin
            is_wr_r <= 1'b0;
            cyc_addr_r <= is_addr_port(ridx); // [RULE24]
            cyc_rd_r <= 1'b1;
            s_axi_rresp <= resp_for(ridx, epp_en);
            if (epp_en && is_epp(ridx)) begin
              st_r <= v17 ? ST_SETUP : ST_WLOW; // [RULE1]
            end else begin
              s_axi_rdata <= {24'h000000, reg_rd};
              s_axi_rvalid <= 1'b1;
              st_r <= ST_RESP;
            end
          end
        end
        ST_WLOW: begin
          // interlocked: outputs stay put until the peripheral shows ready
          if (!nw_s_r) begin
            // byte goes out with the write line, a cycle ahead of the strobe
            if (!cyc_rd_r) begin
              port_data_bus_r <= wbyte_r; // [RULE3]
            end
            st_r <= ST_SETUP; // [RULE2]
          end
        end
        ST_SETUP: begin
          // one cycle of setup on the bus ahead of the strobe
          if (!cyc_rd_r) begin
            port_data_bus_r <= wbyte_r; // [RULE3] [RULE13]
          end
          st_r <= ST_STRB;
        end
        ST_STRB: begin
          if (nw_s_r) begin
            if (v17) begin
              hold_r <= 3'h0;
              st_r <= ST_HOLD;
            end else begin
              st_r <= ST_RESP; // [RULE4] [RULE7]
            end
          end
        end
        ST_HOLD: begin
          // host command still asserted; strobe follows it
          hold_r <= hold_r + 3'h1;
          if (hold_done) begin
            st_r <= ST_RESP; // [RULE14] [RULE15]
          end
        end
        default: begin
          if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            st_r <= ST_IDLE;
          end
          if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
      endcase
      // end of an epp cycle, normal or aborted
      if (cyc_end) begin
        st_r <= ST_RESP;
        if (is_wr_r) begin
          if (!cyc_rd_r) begin
            port_data_bus_r <= wbyte_r; // [RULE4] [RULE14]
          end
          s_axi_bvalid <= 1'b1;
        end else begin
          s_axi_rdata <= {24'h000000, port_data_bus_in}; // [RULE7]
          s_axi_rvalid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // port pins
  // ----------------------------------------
  // write_n: engine level when active, direction bit in 1.7 idle; strobe bit can force low
  wire wn_base = eng_act ? cyc_rd_r : ((epp_en && v17) ? ctl_r[`CTL_PCD] : 1'b1); // [RULE3] [RULE6] [RULE15]
  assign write_n = wn_base & ~ctl_r[`CTL_STROBE]; // [RULE18] [RULE9]
  // strobes are engine-owned only in the strobe window (strb and hold)
  assign data_strobe_n = strb_on ? cyc_addr_r : ~ctl_r[`CTL_AUTOFD]; // [RULE20] [RULE9]
  assign addr_strobe_n = strb_on ? ~cyc_addr_r : ~ctl_r[`CTL_SELIN]; // [RULE20] [RULE9]
  assign port_dir_out = ctl_r[`CTL_PCD] | (eng_act & cyc_rd_r); // [RULE17] [RULE6]
  assign port_data_bus_oe = ~port_dir_out; // [RULE6] [RULE9]
  assign port_data_bus_out = port_data_bus_r;
  // 1.9 stalls from start; 1.7 only while wait_n is low in the strobe window
  assign iochrdy = v17 ? ~stall_follow : ~stall_lock; // [RULE1] [RULE12]
  assign periph_reset_n = ctl_r[`CTL_INIT]; // [RULE21]
  assign irq = intr & ctl_r[`CTL_IRQE]; // [RULE19]
  assign timeout_flag = tmo_r; // [RULE10]

endmodule
`default_nettype wire

// ==== verif/epp_cycle_engine_monitor.sv ====
// checker for the epp cycle engine pins
// assumes one aclk domain; bound to every engine instance
`timescale 1ns/1ps
`default_nettype none
module epp_cycle_engine_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_rvalid,
  input wire [7:0] port_data_bus_out,
  input wire port_data_bus_oe,
  input wire write_n,
  input wire data_strobe_n,
  input wire addr_strobe_n,
  input wire port_dir_out,
  input wire iochrdy,
  input wire timeout_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int stall_cnt;
  wire stb = !data_strobe_n || !addr_strobe_n;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // stall length; margin over the 400-cycle watchdog for sync delay
  always @(posedge aclk) begin
    if (!aresetn || iochrdy) stall_cnt <= 0;
    else stall_cnt <= stall_cnt + 1;
  end
  property p_excl; !(!data_strobe_n && !addr_strobe_n); endproperty
  a_excl: assert property (p_excl) else $error("both strobes low");
  property p_oe; port_data_bus_oe == !port_dir_out; endproperty
  a_oe: assert property (p_oe) else $error("drive enable disagrees with direction");
  property p_setup; $fell(stb) && !port_dir_out |-> $stable(port_data_bus_out); endproperty
  a_setup: assert property (p_setup) else $error("byte moved at strobe");
  property p_match; stb |-> write_n == port_dir_out; endproperty
  a_match: assert property (p_match) else $error("write line against direction");
  property p_lead; $rose(stb) && !port_dir_out |-> $stable(port_data_bus_out) && !$past(write_n); endproperty
  a_lead: assert property (p_lead) else $error("byte or write line late at strobe");
  property p_stall; $rose(stb) |-> !iochrdy; endproperty
  a_stall: assert property (p_stall) else $error("host not held at strobe");
  property p_release; $fell(stb) |-> ##[0:4] (s_axi_bvalid || s_axi_rvalid); endproperty
  a_release: assert property (p_release) else $error("no answer after strobe");
  property p_wdog; stall_cnt <= 410; endproperty
  a_wdog: assert property (p_wdog) else $error("stall outlived watchdog");
  property p_tmo; $rose(timeout_flag) |-> ##[0:2] (s_axi_bvalid || s_axi_rvalid); endproperty
  a_tmo: assert property (p_tmo) else $error("abort without answer");
endmodule
bind epp_cycle_engine epp_cycle_engine_chk epp_cycle_engine_chk_i (.aclk, .aresetn, .s_axi_bvalid,
  .s_axi_rvalid, .port_data_bus_out, .port_data_bus_oe, .write_n, .data_strobe_n, .addr_strobe_n,
  .port_dir_out, .iochrdy, .timeout_flag);
`default_nettype wire

// ==== verif/epp_periph_model.sv ====
// epp peripheral seen across the cable
// assumes engine strobes; answers on aclk edges
`timescale 1ns/1ps
`default_nettype none
module epp_periph_model (
  input wire aclk,
  input wire data_strobe_n,
  input wire addr_strobe_n,
  input wire write_n,
  input wire port_dir_out,
  input wire [7:0] port_data_bus_out,
  input wire hang,
  input wire [7:0] rd_byte,
  output logic wait_n,
  output logic [7:0] pd_in,
  output logic [7:0] got,
  output logic got_addr
);
  int cnt;
  wire stb = !data_strobe_n || !addr_strobe_n;
  initial begin
    {wait_n, pd_in, got, got_addr} = '0;
    cnt = 0;
  end
  // ----------------------------------------
  // handshake
  // ----------------------------------------
  // hang models a dead peripheral so the watchdog must fire
  always @(posedge aclk) begin
    if (stb) begin
      cnt <= cnt + 1;
      if (cnt == 3 && !hang) wait_n <= 1'b1;
      if (port_dir_out) pd_in <= rd_byte;
      else pd_in <= ~pd_in;
      if (!write_n) begin
        got <= port_data_bus_out;
        got_addr <= !addr_strobe_n;
      end
    end else begin
      cnt <= 0;
      wait_n <= 1'b0;
      pd_in <= ~pd_in; // released bus, never stale
    end
  end
endmodule
`default_nettype wire

// ==== verif/tb_epp_cycle_engine.sv ====
// bench for the epp cycle engine with a peripheral model
// assumes the register map of the engine header
`timescale 1ns/1ps
`default_nettype none
`include "epp_cycle_engine_regs.vh"
module tb_epp_cycle_engine;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic intr, err_n, select, paper_end, ack_n, busy, hang;
  logic [7:0] s_axi_awaddr, s_axi_araddr, rd_byte;
  logic [31:0] s_axi_wdata, rdv;
  logic [1:0] resp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wait_n, write_n;
  wire data_strobe_n, addr_strobe_n, periph_reset_n, port_dir_out, iochrdy, irq, timeout_flag;
  wire port_data_bus_oe, got_addr;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] port_data_bus_out, port_data_bus_in, got;
  int fail_count, n_compared, cyc;
  epp_cycle_engine epp_cycle_engine_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_data_bus_in, .port_data_bus_out, .port_data_bus_oe, .wait_n,
    .intr, .err_n, .select, .paper_end, .ack_n, .busy, .write_n, .data_strobe_n, .addr_strobe_n,
    .periph_reset_n, .port_dir_out, .iochrdy, .irq, .timeout_flag);
  epp_periph_model epp_periph_model_i (.aclk, .data_strobe_n, .addr_strobe_n, .write_n, .port_dir_out,
    .port_data_bus_out, .hang, .rd_byte, .wait_n, .pd_in(port_data_bus_in), .got, .got_addr);
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    {s_axi_arvalid, s_axi_rready} <= 2'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic results;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(8'h08);
    chk(rdv, `CTL_RST);
    chk({periph_reset_n, port_dir_out}, 2'h0);
    wr(8'h08, 8'h04);
    chk(periph_reset_n, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_epp19;
    wr(8'h20, 8'h01);
    wr(8'h10, 8'hA5);
    chk({resp, got_addr, got}, 11'h0A5);
    wr(8'h0C, 8'h3C);
    chk({got_addr, got, iochrdy}, 10'h279);
    wr(8'h08, 8'h24); // direction in before a read
    chk({port_dir_out, port_data_bus_oe}, 2'h2);
    rd_byte <= 8'h5A;
    rd(8'h14);
    chk(rdv, 32'h5A);
    wr(8'h18, 8'h77);
    chk({resp, got}, 10'h03C);
    wr(8'h08, 8'h04);
    $display("t_epp19 done");
  endtask
  task automatic t_tmo;
    hang <= 1'b1;
    wr(8'h1C, 8'h11);
    hang <= 1'b0;
    chk(timeout_flag, 1'b1);
    rd(8'h04);
    chk(rdv, 32'hA9);
    wr(8'h04, 8'h00);
    chk(timeout_flag, 1'b1);
    wr(8'h04, 8'h01);
    chk(timeout_flag, 1'b0);
    $display("t_tmo done");
  endtask
  task automatic t_epp17;
    wr(8'h20, 8'h03);
    wr(8'h1C, 8'hC3);
    chk(got, 8'hC3);
    wr(8'h08, 8'h24);
    chk({write_n, port_data_bus_oe}, 2'h2);
    rd_byte <= 8'h96;
    rd(8'h10);
    chk(rdv, 32'h96);
    hang <= 1'b1;
    rd(8'h0C);
    hang <= 1'b0;
    chk(timeout_flag, 1'b1);
    wr(8'h04, 8'h01);
    wr(8'h08, 8'h04);
    $display("t_epp17 done");
  endtask
  task automatic t_misc;
    rd(8'h24);
    chk(resp, `RESP_SLVERR);
    wr(8'h20, 8'h00);
    rd(8'h10);
    chk({resp, rdv[7:0]}, {`RESP_SLVERR, 8'h00});
    wr(8'h08, 8'h14);
    intr <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    intr <= 1'b0;
    @(posedge aclk);
    chk(irq, 1'b0);
    $display("t_misc done");
  endtask
  // clock and run limit; a hang counts as a mismatch
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results;
    end
  end
  // main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, intr, hang} = '0;
    {err_n, select, paper_end, ack_n, busy} = 5'h14;
    {s_axi_awaddr, s_axi_araddr, rd_byte, s_axi_wdata} = '0;
    {fail_count, n_compared, cyc} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_epp19;
    t_tmo;
    t_epp17;
    t_misc;
    results;
  end
endmodule
`default_nettype wire
